// ===== core/rdw_defines.svh
`ifndef RDW_DEFINES_SVH
`define RDW_DEFINES_SVH

// ==========================================================================
// Register byte offsets
// ==========================================================================
`define RDW_ADDR_W            16
`define RDW_OFF_FEATURE_LO    16'h0008
`define RDW_OFF_FEATURE_HI    16'h000c
`define RDW_OFF_WAKE          16'h0014
`define RDW_OFF_IRQ_STATUS    16'h0030
`define RDW_OFF_IRQ_MASK      16'h0034
`define RDW_OFF_DIRECT_SET    16'h0040
`define RDW_OFF_DIRECT_SET_H  16'h0044
`define RDW_OFF_DIRECT_CLR    16'h0048
`define RDW_OFF_DIRECT_CLR_H  16'h004c
`define RDW_OFF_DIRECT_INV    16'h00a0
`define RDW_OFF_DIRECT_INV_H  16'h00a4
`define RDW_OFF_DIRECT_INVA   16'h00b0
`define RDW_OFF_DIRECT_INVA_H 16'h00b4
`define RDW_OFF_DIRECT_SYNC   16'h00c0

// ==========================================================================
// Power-management register fields
// ==========================================================================
`define RDW_WK_QUIESCENT      31
`define RDW_WK_IF_ASLEEP      2
`define RDW_WK_CORE_ASLEEP    1
`define RDW_WK_SLEEP          0
`define RDW_LANE_CTRL         0

// ==========================================================================
// Feature register encodings
// ==========================================================================
`define RDW_SHARED_AFF_SINGLE 2'h0
`define RDW_SHARED_AFF_RSVD   2'h3
`define RDW_RSVD_HI_W         6
`define RDW_RSVD_MID_W        2

// ==========================================================================
// Interrupt status layout and bus answers
// ==========================================================================
`define RDW_IRQ_W             3
`define RDW_RESP_OKAY         2'h0
`define RDW_RESP_SLVERR       2'h2

`endif

// ===== core/rdw_pkg.sv
`default_nettype none

package rdw_pkg;

  typedef enum logic [1:0] {
    RDW_WR_COLLECT = 2'h0,
    RDW_WR_RESP    = 2'h1
  } rdw_wr_state_t;

  typedef enum logic [1:0] {
    RDW_RD_IDLE = 2'h0,
    RDW_RD_RESP = 2'h1
  } rdw_rd_state_t;

  typedef enum logic [2:0] {
    RDW_SEL_NONE,
    RDW_SEL_FEAT_LO,
    RDW_SEL_FEAT_HI,
    RDW_SEL_WAKE,
    RDW_SEL_STATUS,
    RDW_SEL_MASK,
    RDW_SEL_DIRECT
  } rdw_sel_t;

  typedef struct packed {
    logic idleReached;
    logic ifAsleepRose;
    logic wakeRaised;
  } rdw_irq_bits_t;

  typedef struct packed {
    rdw_wr_state_t wrState;
    logic          awready;
    logic          wready;
    logic          awHeld;
    logic          wHeld;
    logic [15:0]   awAddr;
    logic [31:0]   wData;
    logic [3:0]    wStrb;
    logic          bvalid;
    logic [1:0]    bresp;
    rdw_rd_state_t rdState;
    logic          arready;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    logic          coreAsleep;
    logic          sleepReq;
    logic          ifMeta;
    logic          ifAsleep;
    logic          ifAsleepPrev;
    logic          quiescent;
    logic          wakeRequest;
    logic          irqDeliver;
    logic          flushReq;
    rdw_irq_bits_t status;
    rdw_irq_bits_t mask;
    logic          irq;
  } rdw_state_t;

endpackage

`default_nettype wire

// ===== core/rdw_redist_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "rdw_defines.svh"

// Summary of operation
// - Upper feature word holds four affinity bytes.
// - Feature reserved bits always read zero.
// - Shared affinity field encodes chip distinction.
// - Core number field identifies core system-wide.
// - Group-select-disable support bit reads one.
// - Last flag set only in final instance.
// - Direct-injection bit matches direct register presence.
// - Virtual message-interrupt support reads zero.
// - Physical support bit follows configuration.
// - Idle bit set when power-down is safe.
// - Interface-asleep bit reports quiescent core bus.
// - Core awake: no wake request, normal delivery.
// - Core asleep: pending interrupt raises wake request.
// - Sleep bit requests cache flush before power-down.
module rdw_redist_regs #(
  parameter logic [7:0]  AFF_LEVEL_THREE  = 8'h00,
  parameter logic [7:0]  AFF_LEVEL_TWO    = 8'h00,
  parameter logic [7:0]  AFF_LEVEL_ONE    = 8'h00,
  parameter logic [7:0]  AFF_LEVEL_ZERO   = 8'h00,
  parameter logic [1:0]  SHARED_AFFINITY  = 2'h0,
  parameter logic [15:0] CORE_NUMBER      = 16'h0000,
  parameter logic        IS_LAST_INSTANCE = 1'b0,
  parameter logic        DIRECT_SUPPORT   = 1'b0,
  parameter logic        PHYS_SUPPORT     = 1'b1
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        irqPending,
  input  wire logic        interfaceAsleepIn,
  input  wire logic        flushDone,
  output logic             wakeRequest,
  output logic             irqDeliver,
  output logic             flushReq,
  output logic             powerDownSafe,
  output logic             irq
);

  // ========================================================================
  // Feature value
  // ========================================================================
  // A reserved shared-affinity encoding is reported as a single-core system.
  localparam logic [1:0] SHARED_AFF_EFF =
    (SHARED_AFFINITY == `RDW_SHARED_AFF_RSVD) ? `RDW_SHARED_AFF_SINGLE : SHARED_AFFINITY;

  localparam logic [63:0] FEATURE_VALUE = {
    AFF_LEVEL_THREE, AFF_LEVEL_TWO, AFF_LEVEL_ONE, AFF_LEVEL_ZERO,
    {`RDW_RSVD_HI_W{1'b0}},
    SHARED_AFF_EFF,
    CORE_NUMBER,
    {`RDW_RSVD_MID_W{1'b0}},
    1'b1,
    IS_LAST_INSTANCE,
    DIRECT_SUPPORT,
    1'b0,
    1'b0,
    PHYS_SUPPORT
  };

  rdw_pkg::rdw_state_t st;
  rdw_pkg::rdw_state_t nx;

  // ========================================================================
  // Address decode
  // ========================================================================
  // The direct-injection words exist only when that support is configured.
  function automatic rdw_pkg::rdw_sel_t decodeAddr(input logic [15:0] addr);
    rdw_pkg::rdw_sel_t sel;
    sel = rdw_pkg::RDW_SEL_NONE;
    case (addr)
      `RDW_OFF_FEATURE_LO: sel = rdw_pkg::RDW_SEL_FEAT_LO;
      `RDW_OFF_FEATURE_HI: sel = rdw_pkg::RDW_SEL_FEAT_HI;
      `RDW_OFF_WAKE:       sel = rdw_pkg::RDW_SEL_WAKE;
      `RDW_OFF_IRQ_STATUS: sel = rdw_pkg::RDW_SEL_STATUS;
      `RDW_OFF_IRQ_MASK:   sel = rdw_pkg::RDW_SEL_MASK;
      `RDW_OFF_DIRECT_SET, `RDW_OFF_DIRECT_SET_H,
      `RDW_OFF_DIRECT_CLR, `RDW_OFF_DIRECT_CLR_H,
      `RDW_OFF_DIRECT_INV, `RDW_OFF_DIRECT_INV_H,
      `RDW_OFF_DIRECT_INVA, `RDW_OFF_DIRECT_INVA_H,
      `RDW_OFF_DIRECT_SYNC: begin
        if (DIRECT_SUPPORT) begin
          sel = rdw_pkg::RDW_SEL_DIRECT;
        end
      end
      default: sel = rdw_pkg::RDW_SEL_NONE;
    endcase
    return sel;
  endfunction

  // ========================================================================
  // Next-state logic
  // ========================================================================
  always_comb begin
    rdw_pkg::rdw_sel_t     wrSel;
    rdw_pkg::rdw_sel_t     rdSel;
    rdw_pkg::rdw_irq_bits_t setBits;
    rdw_pkg::rdw_irq_bits_t clrBits;
    logic [31:0]           rdWord;
    wrSel   = rdw_pkg::RDW_SEL_NONE;
    rdSel   = rdw_pkg::RDW_SEL_NONE;
    setBits = '0;
    clrBits = '0;
    rdWord  = '0;
    nx      = st;

    // The asleep level arrives from the core side and is synchronised first.
    nx.ifMeta   = interfaceAsleepIn;
    nx.ifAsleep = st.ifMeta;
    nx.ifAsleepPrev = st.ifAsleep;

    nx.wakeRequest = st.coreAsleep && irqPending;
    nx.irqDeliver  = !st.coreAsleep && irqPending;
    nx.flushReq    = st.sleepReq;
    nx.quiescent   = st.sleepReq && flushDone && st.ifAsleep;

    setBits.wakeRaised   = nx.wakeRequest && !st.wakeRequest;
    // The edge is found behind the second stage, so the first stage feeds nothing else.
    setBits.ifAsleepRose = st.ifAsleep && !st.ifAsleepPrev;
    setBits.idleReached  = nx.quiescent && !st.quiescent;

    case (st.wrState)
      rdw_pkg::RDW_WR_COLLECT: begin
        if (s_axi_awvalid && st.awready) begin
          nx.awAddr  = s_axi_awaddr;
          nx.awHeld  = 1'b1;
          nx.awready = 1'b0;
        end
        if (s_axi_wvalid && st.wready) begin
          nx.wData  = s_axi_wdata;
          nx.wStrb  = s_axi_wstrb;
          nx.wHeld  = 1'b1;
          nx.wready = 1'b0;
        end
        if (nx.awHeld && nx.wHeld) begin
          wrSel     = decodeAddr(nx.awAddr);
          nx.bresp  = `RDW_RESP_OKAY;
          nx.bvalid = 1'b1;
          nx.awHeld = 1'b0;
          nx.wHeld  = 1'b0;
          nx.wrState = rdw_pkg::RDW_WR_RESP;
          case (wrSel)
            rdw_pkg::RDW_SEL_WAKE: begin
              if (nx.wStrb[`RDW_LANE_CTRL]) begin
                nx.coreAsleep = nx.wData[`RDW_WK_CORE_ASLEEP];
                nx.sleepReq   = nx.wData[`RDW_WK_SLEEP];
              end
            end
            rdw_pkg::RDW_SEL_STATUS: begin
              if (nx.wStrb[`RDW_LANE_CTRL]) begin
                clrBits = nx.wData[`RDW_IRQ_W-1:0];
              end
            end
            rdw_pkg::RDW_SEL_MASK: begin
              if (nx.wStrb[`RDW_LANE_CTRL]) begin
                nx.mask = nx.wData[`RDW_IRQ_W-1:0];
              end
            end
            // Feature and direct-injection words accept writes without effect.
            rdw_pkg::RDW_SEL_FEAT_LO, rdw_pkg::RDW_SEL_FEAT_HI,
            rdw_pkg::RDW_SEL_DIRECT: nx.bresp = `RDW_RESP_OKAY;
            default: nx.bresp = `RDW_RESP_SLVERR;
          endcase
        end
      end
      rdw_pkg::RDW_WR_RESP: begin
        if (s_axi_bready) begin
          nx.bvalid  = 1'b0;
          nx.awready = 1'b1;
          nx.wready  = 1'b1;
          nx.wrState = rdw_pkg::RDW_WR_COLLECT;
        end
      end
      default: nx.wrState = rdw_pkg::RDW_WR_COLLECT;
    endcase

    case (st.rdState)
      rdw_pkg::RDW_RD_IDLE: begin
        if (s_axi_arvalid && st.arready) begin
          rdSel = decodeAddr(s_axi_araddr);
          nx.rresp = `RDW_RESP_OKAY;
          case (rdSel)
            rdw_pkg::RDW_SEL_FEAT_LO: rdWord = FEATURE_VALUE[31:0];
            rdw_pkg::RDW_SEL_FEAT_HI: rdWord = FEATURE_VALUE[63:32];
            rdw_pkg::RDW_SEL_WAKE: begin
              rdWord[`RDW_WK_QUIESCENT]   = st.quiescent;
              rdWord[`RDW_WK_IF_ASLEEP]   = st.ifAsleep;
              rdWord[`RDW_WK_CORE_ASLEEP] = st.coreAsleep;
              rdWord[`RDW_WK_SLEEP]       = st.sleepReq;
            end
            rdw_pkg::RDW_SEL_STATUS: rdWord[`RDW_IRQ_W-1:0] = st.status;
            rdw_pkg::RDW_SEL_MASK:   rdWord[`RDW_IRQ_W-1:0] = st.mask;
            rdw_pkg::RDW_SEL_DIRECT: rdWord = '0;
            default: nx.rresp = `RDW_RESP_SLVERR;
          endcase
          nx.rdata   = rdWord;
          nx.rvalid  = 1'b1;
          nx.arready = 1'b0;
          nx.rdState = rdw_pkg::RDW_RD_RESP;
        end
      end
      rdw_pkg::RDW_RD_RESP: begin
        if (s_axi_rready) begin
          nx.rvalid  = 1'b0;
          nx.arready = 1'b1;
          nx.rdState = rdw_pkg::RDW_RD_IDLE;
        end
      end
      default: nx.rdState = rdw_pkg::RDW_RD_IDLE;
    endcase

    // A new event wins over a clear written in the same cycle.
    nx.status = (st.status & ~clrBits) | setBits;
    nx.irq    = |(nx.status & nx.mask);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st         <= '0;
      st.awready <= 1'b1;
      st.wready  <= 1'b1;
      st.arready <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready  = st.wready;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_arready = st.arready;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign s_axi_rvalid  = st.rvalid;
  assign wakeRequest   = st.wakeRequest;
  assign irqDeliver    = st.irqDeliver;
  assign flushReq      = st.flushReq;
  assign powerDownSafe = st.quiescent;
  assign irq           = st.irq;

  // ========================================================================
  // Checks
  // ========================================================================
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence seqReadLo;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `RDW_OFF_FEATURE_LO;
  endsequence

  sequence seqReadHi;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `RDW_OFF_FEATURE_HI;
  endsequence

  sequence seqReadWake;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `RDW_OFF_WAKE;
  endsequence

  chk_affinity_upper_word: assert property (
    seqReadHi |=> s_axi_rvalid && s_axi_rdata[31:24] == AFF_LEVEL_THREE
                  && s_axi_rdata[7:0] == AFF_LEVEL_ZERO)
    else $error("Affinity word read back wrong.");

  chk_feature_reserved_zero: assert property (
    seqReadLo |=> s_axi_rdata[31:26] == 6'h00 && s_axi_rdata[7:6] == 2'h0
                  && !s_axi_rdata[2])
    else $error("Feature reserved bits not zero.");

  chk_shared_affinity_field: assert property (
    seqReadLo |=> s_axi_rdata[25:24] != `RDW_SHARED_AFF_RSVD
                  && s_axi_rdata[25:24] == SHARED_AFF_EFF)
    else $error("Shared affinity field wrong.");

  chk_core_number_field: assert property (
    seqReadLo |=> s_axi_rdata[23:8] == CORE_NUMBER)
    else $error("Core number field wrong.");

  chk_support_flags: assert property (
    seqReadLo |=> s_axi_rdata[5] && s_axi_rdata[4] == IS_LAST_INSTANCE
                  && s_axi_rdata[3] == DIRECT_SUPPORT && s_axi_rdata[0] == PHYS_SUPPORT)
    else $error("Feature support flags wrong.");

  chk_virtual_unsupported: assert property (
    seqReadLo |=> s_axi_rvalid && !s_axi_rdata[1])
    else $error("Virtual support bit set.");

  chk_no_wake_awake: assert property (
    !st.coreAsleep ##1 !st.coreAsleep |-> !wakeRequest)
    else $error("Wake request while core awake.");

  chk_deliver_awake: assert property (
    (!st.coreAsleep && irqPending) |=> irqDeliver && !wakeRequest)
    else $error("Interrupt not delivered to awake core.");

  chk_wake_on_pending: assert property (
    (st.coreAsleep && irqPending) |=> wakeRequest && !irqDeliver)
    else $error("No wake request for sleeping core.");

  chk_flush_and_idle: assert property (
    (st.sleepReq && flushDone && st.ifAsleep) |=> flushReq && powerDownSafe)
    else $error("Sleep flush or idle not reported.");

  chk_idle_needs_sleep: assert property (
    !st.sleepReq |=> !powerDownSafe)
    else $error("Idle reported without sleep request.");

  chk_if_asleep_sync: assert property (
    interfaceAsleepIn [*2] |=> st.ifAsleep)
    else $error("Interface asleep not reported.");

  chk_wake_reserved_zero: assert property (
    seqReadWake |=> s_axi_rdata[30:3] == 28'h0000000)
    else $error("Wake reserved bits not zero.");

  chk_irq_from_event: assert property (
    ($rose(st.wakeRequest) && st.mask.wakeRaised) |-> irq [*2])
    else $error("Unmasked event did not raise irq.");

endmodule

`default_nettype wire

// ===== dv/rdw_core_model.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Connected core: pending interrupts, bus quiescence and caches
// ============================================================
module rdw_core_model #(
  parameter int FLUSH_LAT = 5
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic pendCmd,
  input  wire logic asleepCmd,
  input  wire logic flushReq,
  output logic      irqPending,
  output logic      interfaceAsleepIn,
  output logic      flushDone
);
  int flushCount;

  // The cache clean takes several cycles, so the idle indication cannot come early.
  always_ff @(posedge mclk) begin
    if (rst) begin
      irqPending        <= 1'b0;
      interfaceAsleepIn <= 1'b0;
      flushDone         <= 1'b0;
      flushCount        <= 0;
    end else begin
      irqPending        <= pendCmd;
      interfaceAsleepIn <= asleepCmd;
      if (!flushReq) begin
        flushCount <= 0;
      end else if (flushCount < FLUSH_LAT) begin
        flushCount <= flushCount + 1;
      end
      flushDone <= flushReq && (flushCount == FLUSH_LAT);
    end
  end
endmodule

`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rdw_defines.svh"

module tb_top;
  logic        mclk;
  logic        rst;
  logic [15:0] awaddr;
  logic        awvalid;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        bready;
  logic [15:0] araddr;
  logic        arvalid;
  logic        rready;
  logic        pendCmd;
  logic        asleepCmd;
  logic        irqPending;
  logic        ifAsleep;
  logic        flushDone;
  logic [1:0]  awready, wready, bvalid, arready, rvalid;
  logic [1:0]  wakeReq, deliver, flushReq, safe, irqOut;
  logic [1:0]  bresp [2];
  logic [1:0]  rresp [2];
  logic [31:0] rdata [2];
  int          fails;
  int          samplesChecked;
  localparam logic [1:0]  OK = `RDW_RESP_OKAY;
  localparam logic [1:0]  SE = `RDW_RESP_SLVERR;
  localparam logic [15:0] DIRECT_OFFS [9] = '{16'h0040, 16'h0044, 16'h0048, 16'h004c,
                                             16'h00a0, 16'h00a4, 16'h00b0, 16'h00b4, 16'h00c0};

  always #10 mclk = ~mclk;

  for (genvar g = 0; g < 2; g++) begin : g_inst
    rdw_redist_regs #(
      .AFF_LEVEL_THREE (g == 0 ? 8'h12 : 8'h00),
      .AFF_LEVEL_TWO   (g == 0 ? 8'h34 : 8'h00),
      .AFF_LEVEL_ONE   (g == 0 ? 8'h56 : 8'h00),
      .AFF_LEVEL_ZERO  (g == 0 ? 8'h78 : 8'h00),
      .SHARED_AFFINITY (g == 0 ? 2'h1 : 2'h2),
      .CORE_NUMBER     (g == 0 ? 16'habcd : 16'h0102),
      .IS_LAST_INSTANCE(g == 0),
      .DIRECT_SUPPORT  (g == 0),
      .PHYS_SUPPORT    (g == 0)
    ) dut (
      .mclk             (mclk),
      .rst              (rst),
      .s_axi_awaddr     (awaddr),
      .s_axi_awvalid    (awvalid),
      .s_axi_awready    (awready[g]),
      .s_axi_wdata      (wdata),
      .s_axi_wstrb      (wstrb),
      .s_axi_wvalid     (wvalid),
      .s_axi_wready     (wready[g]),
      .s_axi_bresp      (bresp[g]),
      .s_axi_bvalid     (bvalid[g]),
      .s_axi_bready     (bready),
      .s_axi_araddr     (araddr),
      .s_axi_arvalid    (arvalid),
      .s_axi_arready    (arready[g]),
      .s_axi_rdata      (rdata[g]),
      .s_axi_rresp      (rresp[g]),
      .s_axi_rvalid     (rvalid[g]),
      .s_axi_rready     (rready),
      .irqPending       (irqPending),
      .interfaceAsleepIn(ifAsleep),
      .flushDone        (flushDone),
      .wakeRequest      (wakeReq[g]),
      .irqDeliver       (deliver[g]),
      .flushReq         (flushReq[g]),
      .powerDownSafe    (safe[g]),
      .irq              (irqOut[g])
    );
  end

  rdw_core_model #(.FLUSH_LAT(5)) core (
    .mclk             (mclk),
    .rst              (rst),
    .pendCmd          (pendCmd),
    .asleepCmd        (asleepCmd),
    .flushReq         (flushReq[0]),
    .irqPending       (irqPending),
    .interfaceAsleepIn(ifAsleep),
    .flushDone        (flushDone)
  );

  // ============================================================
  // Comparison, bus tasks and closing
  // ============================================================
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Both instances see the same master, so every transfer is judged on each of them.
  task automatic axi_write(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] r0, input logic [1:0] r1);
    logic awDone;
    logic wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge mclk);
      if (!awDone && (&awready)) begin
        awDone = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wDone && (&wready)) begin
        wDone = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge mclk);
    end while (!(&bvalid));
    check("bresp0", {30'h0, bresp[0]}, {30'h0, r0});
    check("bresp1", {30'h0, bresp[1]}, {30'h0, r1});
  endtask

  task automatic axi_read(input logic [15:0] a, input logic [31:0] e0, input logic [31:0] e1,
                          input logic [1:0] r0, input logic [1:0] r1);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge mclk);
    end while (!(&arready));
    arvalid <= 1'b0;
    do begin
      @(posedge mclk);
    end while (!(&rvalid));
    check("rdata0", rdata[0], e0);
    check("rdata1", rdata[1], e1);
    check("rresp0", {30'h0, rresp[0]}, {30'h0, r0});
    check("rresp1", {30'h0, rresp[1]}, {30'h0, r1});
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    tally_and_finish();
  end

  // ============================================================
  // Tests
  // ============================================================
  initial begin
    mclk = 1'b0; rst = 1'b1; awaddr = 16'h0; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'h0;
    wvalid = 1'b0; bready = 1'b1; araddr = 16'h0; arvalid = 1'b0; rready = 1'b1;
    pendCmd = 1'b0; asleepCmd = 1'b0; fails = 0; samplesChecked = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    axi_read(`RDW_OFF_FEATURE_LO, 32'h01abcd39, 32'h02010220, OK, OK);
    axi_read(`RDW_OFF_FEATURE_HI, 32'h12345678, 32'h00000000, OK, OK);
    axi_write(`RDW_OFF_FEATURE_LO, 32'hffffffff, 4'hf, OK, OK);
    axi_write(`RDW_OFF_FEATURE_HI, 32'h00000000, 4'hf, OK, OK);
    axi_read(`RDW_OFF_FEATURE_LO, 32'h01abcd39, 32'h02010220, OK, OK);
    axi_read(`RDW_OFF_FEATURE_HI, 32'h12345678, 32'h00000000, OK, OK);
    foreach (DIRECT_OFFS[i]) axi_read(DIRECT_OFFS[i], 32'h0, 32'h0, OK, SE);
    axi_write(16'h0100, 32'h1, 4'hf, SE, SE);
    axi_read(16'h0100, 32'h0, 32'h0, SE, SE);
    axi_read(`RDW_OFF_WAKE, 32'h0, 32'h0, OK, OK);
    axi_write(`RDW_OFF_WAKE, 32'hffffffff, 4'hf, OK, OK);
    axi_read(`RDW_OFF_WAKE, 32'h3, 32'h3, OK, OK);
    check("flushReq", {30'h0, flushReq}, 32'h3);
    pendCmd <= 1'b1;
    repeat (4) @(posedge mclk);
    check("wakeRequest", {30'h0, wakeReq}, 32'h3);
    check("irqDeliver", {30'h0, deliver}, 32'h0);
    axi_write(`RDW_OFF_WAKE, 32'h0, 4'hf, OK, OK);
    repeat (3) @(posedge mclk);
    check("wakeRequest", {30'h0, wakeReq}, 32'h0);
    check("irqDeliver", {30'h0, deliver}, 32'h3);
    check("flushReq", {30'h0, flushReq}, 32'h0);
    pendCmd <= 1'b0;
    asleepCmd <= 1'b1;
    repeat (4) @(posedge mclk);
    axi_read(`RDW_OFF_WAKE, 32'h4, 32'h4, OK, OK);
    axi_write(`RDW_OFF_WAKE, 32'h1, 4'hf, OK, OK);
    repeat (12) @(posedge mclk);
    axi_read(`RDW_OFF_WAKE, 32'h80000005, 32'h80000005, OK, OK);
    check("powerDownSafe", {30'h0, safe}, 32'h3);
    check("irq", {30'h0, irqOut}, 32'h0);
    axi_read(`RDW_OFF_IRQ_STATUS, 32'h7, 32'h7, OK, OK);
    axi_write(`RDW_OFF_IRQ_MASK, 32'h2, 4'h0, OK, OK);
    axi_read(`RDW_OFF_IRQ_MASK, 32'h0, 32'h0, OK, OK);
    axi_write(`RDW_OFF_IRQ_MASK, 32'hffffff02, 4'h1, OK, OK);
    axi_read(`RDW_OFF_IRQ_MASK, 32'h2, 32'h2, OK, OK);
    check("irq", {30'h0, irqOut}, 32'h3);
    axi_write(`RDW_OFF_IRQ_STATUS, 32'h2, 4'h1, OK, OK);
    axi_read(`RDW_OFF_IRQ_STATUS, 32'h5, 32'h5, OK, OK);
    check("irq", {30'h0, irqOut}, 32'h0);
    axi_write(`RDW_OFF_IRQ_STATUS, 32'h7, 4'h1, OK, OK);
    axi_read(`RDW_OFF_IRQ_STATUS, 32'h0, 32'h0, OK, OK);
    axi_write(`RDW_OFF_IRQ_MASK, 32'h1, 4'h1, OK, OK);
    axi_write(`RDW_OFF_WAKE, 32'h2, 4'h1, OK, OK);
    pendCmd <= 1'b1;
    repeat (4) @(posedge mclk);
    check("wakeRequest", {30'h0, wakeReq}, 32'h3);
    check("irqDeliver", {30'h0, deliver}, 32'h0);
    check("irq", {30'h0, irqOut}, 32'h3);
    axi_read(`RDW_OFF_IRQ_STATUS, 32'h1, 32'h1, OK, OK);
    tally_and_finish();
  end
endmodule

`default_nettype wire
